/* rtl/rfr_regs.sv */
// Register bank of the reader front end: filter, regulator, status and timeout
module rfr_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Chip enable pin
    input wire logic enable_pin,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Events from the protocol engine
    input wire rfr_pkg::rfr_events_s events,
    input wire logic [3:0] fifo_level,
    // Receiver and regulator controls
    output rfr_pkg::rfr_rx_setting_s rx_setting,
    output logic [2:0] gain_reduction_db5,
    output rfr_pkg::rfr_regulator_s regulator,
    output logic modulation_to_amplifier,
    output logic external_demod_input,
    output logic protocol_write,
    // Interrupt request to host
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Enable pin synchroniser
    logic en_meta;
    logic en_sync;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            en_meta <= 1'b0;
            en_sync <= 1'b0;
        end else begin
            en_meta <= enable_pin;
            en_sync <= en_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic wr_access;
    logic rd_access;
    logic [7:0] reg_idx;
    logic hit;
    logic [7:0] wbyte;

    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = (idx == rfr_pkg::RFR_IDX_FILTER) || (idx == rfr_pkg::RFR_IDX_REGULATOR) ||
                    (idx == rfr_pkg::RFR_IDX_STATUS) || (idx == rfr_pkg::RFR_IDX_MASK) ||
                    (idx == rfr_pkg::RFR_IDX_NORESP) || (idx == rfr_pkg::RFR_IDX_PROTOCOL);
    endfunction

    assign reg_idx = {2'h0, paddr[7:2]};
    assign hit = is_mapped(reg_idx) && (paddr[1:0] == 2'h0);
    assign wr_access = psel && penable && pwrite && hit;
    assign rd_access = psel && penable && !pwrite && hit;
    assign wbyte = pwdata[7:0];
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    // Protocol control register write reloads filter and no-response defaults, clears status and timer
    assign protocol_write = wr_access && (reg_idx == rfr_pkg::RFR_IDX_PROTOCOL);

    ////////////////////////////////////////////////////////////////////////////////
    // Protocol control register
    logic [7:0] protocol_ctrl;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            protocol_ctrl <= rfr_pkg::RFR_PROTOCOL_RST;
        end else if (!en_sync) begin
            protocol_ctrl <= rfr_pkg::RFR_PROTOCOL_RST;
        end else if (protocol_write) begin
            protocol_ctrl <= wbyte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receiver filter and gain setting
    logic [7:0] filter_reg;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            filter_reg <= rfr_pkg::RFR_FILTER_RST;
        end else if (!en_sync || protocol_write) begin
            filter_reg <= rfr_pkg::RFR_FILTER_RST;
        end else if (wr_access && reg_idx == rfr_pkg::RFR_IDX_FILTER) begin
            filter_reg <= wbyte;
        end
    end

    // Filter band and AGC selections drive the analog front end
    assign rx_setting = rfr_pkg::rfr_rx_setting_s'(filter_reg);

    // Gain drop in 5 dB steps: 01 5 dB, 10 10 dB, 11 15 dB; band bit 4 adds its own 7 dB
    assign gain_reduction_db5 = {1'b0, rx_setting.gain_drop};

    ////////////////////////////////////////////////////////////////////////////////
    // Regulator and I/O control
    logic [7:0] regulator_reg;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            regulator_reg <= rfr_pkg::RFR_REGULATOR_RST;
        end else if (!en_sync) begin
            regulator_reg <= rfr_pkg::RFR_REGULATOR_RST;
        end else if (wr_access && reg_idx == rfr_pkg::RFR_IDX_REGULATOR) begin
            regulator_reg <= wbyte & ~rfr_pkg::RFR_REGULATOR_UNUSED;
        end
    end

    // Auto select, amplifier, low I/O and voltage code, bit 2 the MSB
    assign regulator = {regulator_reg[7:5], regulator_reg[2:0]};

    // External amplifier routes modulation out and takes demodulated input
    assign modulation_to_amplifier = regulator.external_amplifier_enable && events.tx_start;
    assign external_demod_input = regulator.external_amplifier_enable;

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt mask and no-response time
    logic [7:0] mask_reg;
    logic [7:0] noresp_reg;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mask_reg <= rfr_pkg::RFR_MASK_RST;
        end else if (!en_sync) begin
            mask_reg <= rfr_pkg::RFR_MASK_RST;
        end else if (wr_access && reg_idx == rfr_pkg::RFR_IDX_MASK) begin
            mask_reg <= wbyte;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            noresp_reg <= rfr_pkg::RFR_NORESP_RST;
        end else if (!en_sync || protocol_write) begin
            noresp_reg <= rfr_pkg::RFR_NORESP_RST;
        end else if (wr_access && reg_idx == rfr_pkg::RFR_IDX_NORESP) begin
            noresp_reg <= wbyte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // No-response timer: starts at end of transmit, counts steps of the step time
    localparam int STEP_W = $clog2(rfr_pkg::RFR_STEP_CYCLES + 1);
    logic timer_run;
    logic [STEP_W-1:0] step_cnt;
    logic [7:0] step_num;
    logic noresp_event;

    assign noresp_event = timer_run && (step_cnt == STEP_W'(rfr_pkg::RFR_STEP_CYCLES - 1)) &&
                          (step_num + 8'h01 >= noresp_reg);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            timer_run <= 1'b0;
            step_cnt <= '0;
            step_num <= 8'h00;
        end else if (!en_sync || protocol_write || events.rx_sof || events.tx_start) begin
            timer_run <= 1'b0;
            step_cnt <= '0;
            step_num <= 8'h00;
        end else if (events.tx_end) begin
            timer_run <= 1'b1;
            step_cnt <= '0;
            step_num <= 8'h00;
        end else if (noresp_event) begin
            timer_run <= 1'b0;
        end else if (timer_run) begin
            if (step_cnt == STEP_W'(rfr_pkg::RFR_STEP_CYCLES - 1)) begin
                step_cnt <= '0;
                step_num <= step_num + 8'h01;
            end else begin
                step_cnt <= step_cnt + STEP_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // FIFO level event on entry to the out-of-band region
    logic fifo_out;
    logic fifo_out_d;

    assign fifo_out = (fifo_level < rfr_pkg::RFR_FIFO_LOW) || (fifo_level > rfr_pkg::RFR_FIFO_HIGH);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fifo_out_d <= 1'b0;
        end else begin
            fifo_out_d <= fifo_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status: sticky, cleared by reset, protocol write or read
    logic [7:0] status_reg;
    logic [7:0] set_bits;
    logic status_clear;

    always_comb begin
        set_bits = 8'h00;
        set_bits[rfr_pkg::RFR_ST_TX] = events.tx_start;
        set_bits[rfr_pkg::RFR_ST_RX] = events.rx_sof;
        set_bits[rfr_pkg::RFR_ST_FIFO] = fifo_out && !fifo_out_d;
        set_bits[rfr_pkg::RFR_ST_CRC] = events.crc_err;
        set_bits[rfr_pkg::RFR_ST_PAR] = events.parity_err;
        set_bits[rfr_pkg::RFR_ST_FRM] = events.framing_err;
        set_bits[rfr_pkg::RFR_ST_COL] = events.collision;
        set_bits[rfr_pkg::RFR_ST_NORESP] = noresp_event;
    end

    assign status_clear = !en_sync || protocol_write ||
                          (rd_access && reg_idx == rfr_pkg::RFR_IDX_STATUS);

    // A set in a read or protocol-write clearing cycle survives the clear; enable low loads the reset value
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            status_reg <= rfr_pkg::RFR_STATUS_RST;
        end else if (!en_sync) begin
            status_reg <= rfr_pkg::RFR_STATUS_RST;
        end else if (status_clear) begin
            status_reg <= set_bits;
        end else begin
            status_reg <= status_reg | set_bits;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt request: end-of-frame for TX/RX, masked sources for the rest
    logic [5:0] irq_src;

    assign irq_src = set_bits[5:0] & mask_reg[5:0];

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else if (events.tx_end || events.rx_end || (|irq_src)) begin
            irq <= en_sync;
        end else if (status_clear) begin
            irq <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case ({2'h0, paddr[7:2]})
                rfr_pkg::RFR_IDX_FILTER: prdata <= {24'h00_0000, filter_reg};
                rfr_pkg::RFR_IDX_REGULATOR: prdata <= {24'h00_0000, regulator_reg};
                rfr_pkg::RFR_IDX_STATUS: prdata <= {24'h00_0000, status_reg | set_bits};
                rfr_pkg::RFR_IDX_MASK: prdata <= {24'h00_0000, mask_reg};
                rfr_pkg::RFR_IDX_NORESP: prdata <= {24'h00_0000, noresp_reg};
                rfr_pkg::RFR_IDX_PROTOCOL: prdata <= {24'h00_0000, protocol_ctrl};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

/* include/rfr_pkg.sv */
// Package with offsets, field positions, reset values and carriers for the reader register bank
// Overview of operation
// - Filter setting loads 0x40 on reset, enable low, protocol write
// - Bit 7 picks 110-570 kHz band
// - Bit 6 picks 200-900 kHz band
// - Bit 5 picks 450 kHz-1.5 MHz band
// - Bit 4 picks wide band, gain -7 dB
// - Bits 3:2 drop gain 5/10/15 dB
// - Bit 1 moves AGC threshold to 3x
// - Bit 0 lets AGC act anytime
// - Regulator register loads 0x87; protocol write ignored
// - Bit 7 picks automatic regulator setting
// - External amplifier bit reroutes receiver and modulation pin
// - Bits 2:0 set regulator voltage, MSB first
// - Status clears on reset, protocol write, read
// - Status clear drops interrupt request unless a request source fires in the same cycle
// - Transmit flag sets at start, request at end
// - Receive flag sets at start-of-frame, request at end
// - FIFO flag when below 4 or above 8
// - Bits 4,3,2 flag CRC, parity, framing errors
// - Bit 1 flags collision
// - Bit 0 flags no-response timeout
// - Timeout counted from end-of-frame in 37.76 us steps
// - Mask register gates each error interrupt source
package rfr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices (printed offsets); byte address is four times the index
    localparam logic [7:0] RFR_IDX_FILTER = 8'h0A;
    localparam logic [7:0] RFR_IDX_REGULATOR = 8'h0B;
    localparam logic [7:0] RFR_IDX_STATUS = 8'h0C;
    localparam logic [7:0] RFR_IDX_MASK = 8'h0D;
    localparam logic [7:0] RFR_IDX_NORESP = 8'h0E;
    localparam logic [7:0] RFR_IDX_PROTOCOL = 8'h01;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RFR_FILTER_RST = 8'h40;
    localparam logic [7:0] RFR_REGULATOR_RST = 8'h87;
    localparam logic [7:0] RFR_STATUS_RST = 8'h00;
    localparam logic [7:0] RFR_MASK_RST = 8'h3E;
    localparam logic [7:0] RFR_NORESP_RST = 8'h0E;
    localparam logic [7:0] RFR_PROTOCOL_RST = 8'h02;
    localparam logic [7:0] RFR_REGULATOR_UNUSED = 8'h18;

    ////////////////////////////////////////////////////////////////////////////////
    // Status bit positions
    localparam int RFR_ST_TX = 7;
    localparam int RFR_ST_RX = 6;
    localparam int RFR_ST_FIFO = 5;
    localparam int RFR_ST_CRC = 4;
    localparam int RFR_ST_PAR = 3;
    localparam int RFR_ST_FRM = 2;
    localparam int RFR_ST_COL = 1;
    localparam int RFR_ST_NORESP = 0;

    // FIFO level limits
    localparam logic [3:0] RFR_FIFO_LOW = 4'h4;
    localparam logic [3:0] RFR_FIFO_HIGH = 4'h8;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing: clock and timeout step
    localparam int RFR_CLK_MHZ = 125;
    localparam int RFR_STEP_NS_X100 = 3776000;
    localparam int RFR_STEP_CYCLES = (RFR_STEP_NS_X100 / 100 * RFR_CLK_MHZ) / 1000;

    ////////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic low_band_filter_sel;
        logic mid_band_filter_sel;
        logic manchester_band_filter_sel;
        logic wide_band_filter_sel;
        logic [1:0] gain_drop;
        logic agc_level_3x;
        logic agc_unlimited;
    } rfr_rx_setting_s;

    typedef struct packed {
        logic auto_regulator;
        logic external_amplifier_enable;
        logic low_io_voltage;
        logic [2:0] volt_set;
    } rfr_regulator_s;

    typedef struct packed {
        logic tx_start;
        logic tx_end;
        logic rx_sof;
        logic rx_end;
        logic crc_err;
        logic parity_err;
        logic framing_err;
        logic collision;
    } rfr_events_s;

endpackage

/* dv/rfr_regs_sva.sv */
// Port-level assertion checker for the reader register bank
module rfr_regs_sva (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Enable pin and APB
    input wire logic enable_pin,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Engine side
    input wire rfr_pkg::rfr_events_s events,
    input wire logic [3:0] fifo_level,
    // Controls and request
    input wire rfr_pkg::rfr_rx_setting_s rx_setting,
    input wire logic [2:0] gain_reduction_db5,
    input wire rfr_pkg::rfr_regulator_s regulator,
    input wire logic modulation_to_amplifier,
    input wire logic external_demod_input,
    input wire logic protocol_write,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    logic mapped;
    // Decoded addresses that the bank answers
    assign mapped = paddr inside {8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h04};
    ////////////////////////////////////////
    sequence s_stat_rd;
        psel && penable && !pwrite && paddr == 8'h30;
    endsequence
    sequence s_quiet;
        events == 8'h00 && $stable(fifo_level);
    endsequence
    property p_access;
        psel && penable |-> pready && (pslverr == !mapped);
    endproperty
    property p_reset;
        $rose(nrst) |-> rx_setting == 8'h40 && regulator == 6'h27 && !irq;
    endproperty
    property p_filt_rld;
        protocol_write |=> rx_setting == 8'h40;
    endproperty
    property p_reg_keep;
        protocol_write |=> regulator == $past(regulator);
    endproperty
    property p_gain;
        gain_reduction_db5 == {1'b0, rx_setting.gain_drop};
    endproperty
    property p_extamp;
        modulation_to_amplifier == (regulator.external_amplifier_enable && events.tx_start)
            && external_demod_input == regulator.external_amplifier_enable;
    endproperty
    property p_end_irq;
        events.tx_end || events.rx_end |=> irq;
    endproperty
    property p_early;
        !irq && (events & 8'h5F) == 8'h00 && events != 8'h00 && $stable(fifo_level) |=> !irq;
    endproperty
    property p_rd_clr;
        s_stat_rd ##0 s_quiet |=> !irq;
    endproperty
    property p_en_low;
        !enable_pin [*4] |-> rx_setting == 8'h40 && regulator == 6'h27 && !irq;
    endproperty
    a_access: assert property (p_access) else $error("apb answer wrong");
    a_reset: assert property (p_reset) else $error("bad value after reset");
    a_filt_rld: assert property (p_filt_rld) else $error("filter not reloaded");
    a_reg_keep: assert property (p_reg_keep) else $error("regulator reloaded");
    a_gain: assert property (p_gain) else $error("gain drop wrong");
    a_extamp: assert property (p_extamp) else $error("amplifier routing wrong");
    a_end_irq: assert property (p_end_irq) else $error("no request at end");
    a_early: assert property (p_early) else $error("request at start");
    a_rd_clr: assert property (p_rd_clr) else $error("request kept after read");
    a_en_low: assert property (p_en_low) else $error("enable low not reset");
endmodule
bind rfr_regs rfr_regs_sva i_sva (.ref_clk(ref_clk), .nrst(nrst), .enable_pin(enable_pin), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .events(events),
    .fifo_level(fifo_level), .rx_setting(rx_setting), .gain_reduction_db5(gain_reduction_db5),
    .regulator(regulator), .modulation_to_amplifier(modulation_to_amplifier),
    .external_demod_input(external_demod_input), .protocol_write(protocol_write), .irq(irq));

/* dv/rfr_host.sv */
// APB master model standing in for the host controller
module rfr_host (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Request from the bench
    input wire logic go,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Transfer result
    output logic done,
    output logic rd,
    output logic [32:0] result
);
    timeunit 1ns;
    timeprecision 1ps;
    // Setup, access until pready, then release with scrambled address and data
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            psel <= 1'b0;
            penable <= 1'b0;
            pwrite <= 1'b0;
            paddr <= 8'h00;
            pwdata <= 32'h0;
            done <= 1'b0;
            rd <= 1'b0;
            result <= 33'h0;
        end else begin
            done <= 1'b0;
            if (psel && penable && pready) begin
                psel <= 1'b0;
                penable <= 1'b0;
                done <= 1'b1;
                rd <= !pwrite;
                result <= {pslverr, prdata};
                paddr <= ~paddr;
                pwdata <= ~pwdata;
            end else if (psel) begin
                penable <= 1'b1;
            end else if (go) begin
                psel <= 1'b1;
                pwrite <= wr;
                paddr <= addr;
                pwdata <= {24'h0, wdata};
            end
        end
    end
endmodule

/* dv/test_rx_setting_regulator_irq_status_regs.sv */
// Self-checking bench for the reader register bank
module test_rx_setting_regulator_irq_status_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, nrst, enable_pin, go, wr, done, rd, psel, penable, pwrite, pready, pslverr, irq;
    logic mod_amp, ext_demod, protocol_write;
    logic [7:0] addr, wdata, paddr, v;
    logic [31:0] pwdata, prdata, lfsr;
    logic [32:0] result;
    logic [32:0] expq[$];
    logic [3:0] fifo_level;
    logic [2:0] gain_db5;
    rfr_pkg::rfr_events_s events;
    rfr_pkg::rfr_rx_setting_s rx_setting;
    rfr_pkg::rfr_regulator_s regulator;
    int n_mismatch, tests_run, i;
    int evb[6] = '{7, 5, 3, 2, 1, 0};
    int stb[6] = '{7, 6, 4, 3, 2, 1};
    logic [3:0] fl[4] = '{4'h4, 4'h3, 4'h8, 4'h9};
    logic [7:0] fx[4] = '{8'h00, 8'h20, 8'h00, 8'h20};
    rfr_regs i_dut (.ref_clk(ref_clk), .nrst(nrst), .enable_pin(enable_pin), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .events(events), .fifo_level(fifo_level), .rx_setting(rx_setting), .gain_reduction_db5(gain_db5),
        .regulator(regulator), .modulation_to_amplifier(mod_amp), .external_demod_input(ext_demod),
        .protocol_write(protocol_write), .irq(irq));
    rfr_host i_host (.ref_clk(ref_clk), .nrst(nrst), .go(go), .wr(wr), .addr(addr), .wdata(wdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .done(done), .rd(rd), .result(result));
    // Clock of 8 ns
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(string name, logic [32:0] exp, logic [32:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // One transfer through the host model; a read notes its expected answer first
    task automatic xfer(logic w, logic [7:0] a, logic [7:0] d, logic e = 1'b0);
        int k;
        if (!w) expq.push_back({e, 24'h0, d});
        @(posedge ref_clk);
        go <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        go <= 1'b0;
        for (k = 0; k < 20 && !done; k++) @(negedge ref_clk);
        if (!done) begin
            n_mismatch++;
            results();
        end
    endtask
    task automatic pulse(logic [7:0] ev);
        @(posedge ref_clk);
        events <= ev;
        @(posedge ref_clk);
        events <= 8'h00;
        @(negedge ref_clk);
    endtask
    // Finished reads against the oldest note
    always @(posedge ref_clk) begin
        if (done && rd) cmp("read", expq.pop_front(), result);
    end
    ////////////////////////////////////////
    initial begin
        {nrst, go, wr, addr, wdata, events, n_mismatch, tests_run} = '0;
        enable_pin = 1'b1;
        fifo_level = 4'h6;
        lfsr = 32'h56BB;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        xfer(1'b0, 8'h28, 8'h40);
        xfer(1'b0, 8'h2C, 8'h87);
        xfer(1'b0, 8'h30, 8'h00);
        xfer(1'b0, 8'h34, 8'h3E);
        xfer(1'b0, 8'h3C, 8'h00, 1'b1);
        xfer(1'b1, 8'h29, 8'h55);
        xfer(1'b0, 8'h28, 8'h40);
        for (i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            v = lfsr[7:0];
            xfer(1'b1, 8'h28, v);
            xfer(1'b0, 8'h28, v);
            cmp("rx_setting", {25'h0, v}, {25'h0, rx_setting});
            cmp("gain", {31'h0, v[3:2]}, {30'h0, gain_db5});
            v = lfsr[15:8] | 8'h20;
            xfer(1'b1, 8'h2C, v);
            xfer(1'b0, 8'h2C, v & 8'hE7);
            cmp("regulator", {27'h0, v[7:5], v[2:0]}, {27'h0, regulator});
            cmp("ext_demod", {32'h0, v[6]}, {32'h0, ext_demod});
        end
        xfer(1'b1, 8'h2C, 8'h47);
        pulse(8'h08);
        xfer(1'b1, 8'h04, 8'h02);
        cmp("irq", 33'h0, {32'h0, irq});
        xfer(1'b0, 8'h30, 8'h00);
        xfer(1'b0, 8'h28, 8'h40);
        xfer(1'b0, 8'h2C, 8'h47);
        for (i = 0; i < 6; i++) begin
            pulse(8'h01 << evb[i]);
            xfer(1'b0, 8'h30, 8'h01 << stb[i]);
            xfer(1'b0, 8'h30, 8'h00);
        end
        pulse(8'h40);
        cmp("irq", 33'h1, {32'h0, irq});
        pulse(8'h20);
        xfer(1'b0, 8'h30, 8'h40);
        cmp("irq", 33'h0, {32'h0, irq});
        pulse(8'h10);
        cmp("irq", 33'h1, {32'h0, irq});
        for (i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            fifo_level <= fl[i];
            xfer(1'b0, 8'h30, fx[i]);
        end
        @(posedge ref_clk);
        fifo_level <= 4'h6;
        xfer(1'b1, 8'h38, 8'h01);
        pulse(8'h40);
        repeat (4600) @(posedge ref_clk);
        xfer(1'b0, 8'h30, 8'h00);
        repeat (200) @(posedge ref_clk);
        cmp("irq", 33'h0, {32'h0, irq});
        xfer(1'b0, 8'h30, 8'h01);
        xfer(1'b1, 8'h28, 8'h99);
        @(posedge ref_clk);
        enable_pin <= 1'b0;
        repeat (6) @(posedge ref_clk);
        enable_pin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        xfer(1'b0, 8'h28, 8'h40);
        xfer(1'b0, 8'h2C, 8'h87);
        results();
    end
endmodule
